//--- shared/fmt_pkg.sv
// Summary of operation
// - Pattern code 000 passes conversion results through the coding stage
// - Pattern code 001 drives flag and bits low
// - Pattern code 011 drives flag and bits high
// - Pattern code 101 toggles two checkerboard words
// - Pattern code 111 toggles all zeros, all ones
// - Format bit 2 enables alternate bit polarity
// - Format bit 1 enables the output scrambler
// - Format bit 0 selects two's complement coding
// - Polarity alternation forces offset binary coding
// - Software reset clears the format register
`default_nettype none
package fmt_pkg;
  // Word widths
  localparam int SAMPLE_W = 14;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  // Register addresses
  localparam logic [6:0] RESET_REG_ADDR = 7'h00;
  localparam logic [6:0] FORMAT_REG_ADDR = 7'h04;
  // Reset register field
  localparam int SOFT_RESET_BIT = 7;
  // Format register fields
  localparam int SIGNED_SEL_BIT = 0;
  localparam int SCRAMBLE_BIT = 1;
  localparam int POLARITY_BIT = 2;
  localparam int PATTERN_LSB = 3;
  localparam int PATTERN_MSB = 5;
  localparam int FORMAT_USED_W = 6;
  localparam logic [5:0] FORMAT_RESET = 6'h00;
  // Fixed output words, flag in the top bit
  localparam logic [14:0] CHECK_WORD_A = 15'h55A5;
  localparam logic [14:0] CHECK_WORD_B = 15'h2A5A;
  localparam logic [14:0] WORD_ZEROS = 15'h0000;
  localparam logic [14:0] WORD_ONES = 15'h7FFF;
  // Odd-numbered sample bits
  localparam logic [13:0] ODD_BIT_MASK = 14'h2AAA;
  // Test pattern codes
  typedef enum logic [2:0] {
    PAT_OFF = 3'b000,
    PAT_ZEROS = 3'b001,
    PAT_ONES = 3'b011,
    PAT_CHECKER = 3'b101,
    PAT_TOGGLE = 3'b111
  } pattern_e;
endpackage
`default_nettype wire

//--- shared/fmt_if.sv
`default_nettype none
// Carries a raw sample into the encoder and the coded word back
interface fmt_if;
  logic [13:0] raw_bits; // Offset binary from the core
  logic raw_ovr; // Over-range from the core
  logic polarity_alt; // Alternate polarity enable
  logic scramble; // Scrambler enable
  logic signed_sel; // Two's complement select
  logic [13:0] enc_bits; // Coded sample bits
  logic enc_ovr; // Coded over-range flag
  modport ctl (output raw_bits, raw_ovr, polarity_alt, scramble, signed_sel,
    input enc_bits, enc_ovr);
  modport enc (input raw_bits, raw_ovr, polarity_alt, scramble, signed_sel,
    output enc_bits, enc_ovr);
endinterface
`default_nettype wire

//--- rtl/sample_encoder.sv
`default_nettype none
// Pure combinational coding of one sample word
module sample_encoder (
  // Link to the formatter
  fmt_if.enc io
);
  logic [13:0] coded; // Word after coding choice

  // Coding and scrambling of the sample bits
  always_comb
  begin
    coded = io.raw_bits;
    // Polarity alternation wins over the signed select
    if (io.polarity_alt)
    begin
      coded = io.raw_bits ^ fmt_pkg::ODD_BIT_MASK;
    end
    else if (io.signed_sel)
    begin
      coded[13] = ~io.raw_bits[13];
    end
    // Scrambler keyed by the LSB, so a receiver can undo it
    if (io.scramble)
    begin
      coded[13:1] = coded[13:1] ^ {13{coded[0]}};
    end
    io.enc_bits = coded;
    io.enc_ovr = io.raw_ovr;
  end
endmodule
`default_nettype wire

//--- rtl/adc_output_data_formatter.sv
`default_nettype none
// Output data formatter: register access, pattern substitution and coding
module adc_output_data_formatter (
  // Clock, reset and enable
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_CE,
  // Register access
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic [6:0] I_REG_ADDR,
  input wire logic [7:0] I_REG_WDATA,
  output logic [7:0] O_REG_RDATA,
  output logic O_REG_RVALID,
  // Samples from the conversion core
  input wire logic I_SAMPLE_VALID,
  input wire logic [13:0] I_SAMPLE_BITS,
  input wire logic I_OVERRANGE_FLAG,
  // Samples to the capturing logic
  output logic O_SAMPLE_VALID,
  output logic [13:0] O_SAMPLE_BITS,
  output logic O_OVERRANGE_FLAG
);
  // All state of the block
  typedef struct packed {
    logic [5:0] output_data_format; // Used format bits
    logic phase; // Toggle pattern phase
    logic [13:0] bits; // Output sample bits
    logic ovr; // Output over-range flag
    logic vld; // Output word strobe
    logic [7:0] rdata; // Read data
    logic rvld; // Read data strobe
  } state_s;

  state_s state_r; // Registered state
  state_s state_nxt; // Next state
  fmt_if link (); // Encoder link
  fmt_pkg::pattern_e pattern; // Current pattern code
  logic [14:0] word; // Flag plus bits to send
  logic toggling; // A two-word pattern is active

  // Feed the encoder from the current format
  assign link.raw_bits = I_SAMPLE_BITS;
  assign link.raw_ovr = I_OVERRANGE_FLAG;
  assign link.polarity_alt = state_r.output_data_format[fmt_pkg::POLARITY_BIT];
  assign link.scramble = state_r.output_data_format[fmt_pkg::SCRAMBLE_BIT];
  assign link.signed_sel = state_r.output_data_format[fmt_pkg::SIGNED_SEL_BIT];
  assign pattern = fmt_pkg::pattern_e'(
    state_r.output_data_format[fmt_pkg::PATTERN_MSB:fmt_pkg::PATTERN_LSB]);

  sample_encoder u_encoder (
    .io(link.enc)
  );

  // Select the word that leaves the block
  always_comb
  begin
    toggling = 1'b0;
    unique case (pattern)
      fmt_pkg::PAT_OFF: word = {link.enc_ovr, link.enc_bits};
      fmt_pkg::PAT_ZEROS: word = fmt_pkg::WORD_ZEROS;
      fmt_pkg::PAT_ONES: word = fmt_pkg::WORD_ONES;
      fmt_pkg::PAT_CHECKER:
      begin
        toggling = 1'b1;
        word = state_r.phase ? fmt_pkg::CHECK_WORD_B : fmt_pkg::CHECK_WORD_A;
      end
      fmt_pkg::PAT_TOGGLE:
      begin
        toggling = 1'b1;
        word = state_r.phase ? fmt_pkg::WORD_ONES : fmt_pkg::WORD_ZEROS;
      end
      // Unused codes fall back to live data rather than garbage
      default: word = {link.enc_ovr, link.enc_bits};
    endcase
  end

  // Next state
  always_comb
  begin
    state_nxt = state_r;
    state_nxt.vld = 1'b0;
    state_nxt.rvld = 1'b0;
    // Sample path
    if (I_SAMPLE_VALID)
    begin
      state_nxt.vld = 1'b1;
      state_nxt.ovr = word[14];
      state_nxt.bits = word[13:0];
      // Phase advances once per sample; parked low otherwise
      state_nxt.phase = toggling ? ~state_r.phase : 1'b0;
    end
    else if (!toggling)
    begin
      state_nxt.phase = 1'b0;
    end
    // Register writes
    if (I_REG_WR)
    begin
      if (I_REG_ADDR == fmt_pkg::FORMAT_REG_ADDR)
      begin
        // Upper two bits are never stored
        state_nxt.output_data_format = I_REG_WDATA[5:0];
      end
      else if (I_REG_ADDR == fmt_pkg::RESET_REG_ADDR &&
        I_REG_WDATA[fmt_pkg::SOFT_RESET_BIT])
      begin
        // Reset bit self-clears: it is never stored
        state_nxt.output_data_format = fmt_pkg::FORMAT_RESET;
        state_nxt.phase = 1'b0;
      end
    end
    // Register reads; unmapped addresses return zero
    if (I_REG_RD)
    begin
      state_nxt.rvld = 1'b1;
      if (I_REG_ADDR == fmt_pkg::FORMAT_REG_ADDR)
      begin
        state_nxt.rdata = {2'h0, state_r.output_data_format};
      end
      else
      begin
        state_nxt.rdata = 8'h00;
      end
    end
  end

  // State register: reset clears it even while the enable is low, otherwise frozen while the enable is low
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      state_r <= '0;
    end
    else if (I_CE)
    begin
      state_r <= state_nxt;
    end
  end

  // Outputs straight from the state register
  assign O_SAMPLE_VALID = state_r.vld;
  assign O_SAMPLE_BITS = state_r.bits;
  assign O_OVERRANGE_FLAG = state_r.ovr;
  assign O_REG_RDATA = state_r.rdata;
  assign O_REG_RVALID = state_r.rvld;

  // Checks
  // Format writes kept out so each check sees one settled setting
  logic live; // A sample is taken this cycle
  assign live = I_CE && I_SAMPLE_VALID &&
    !(I_REG_WR && I_REG_ADDR == fmt_pkg::FORMAT_REG_ADDR);

  a_normal_pass: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    live && state_r.output_data_format == 6'h00
    |=> O_SAMPLE_VALID && O_SAMPLE_BITS == $past(I_SAMPLE_BITS) &&
      O_OVERRANGE_FLAG == $past(I_OVERRANGE_FLAG))
    else $error("normal data not passed through");
  a_zero_pattern: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    live && pattern == fmt_pkg::PAT_ZEROS
    |=> O_SAMPLE_BITS == 14'h0000 && !O_OVERRANGE_FLAG)
    else $error("zero pattern wrong");
  a_ones_pattern: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    live && pattern == fmt_pkg::PAT_ONES
    |=> O_SAMPLE_BITS == 14'h3FFF && O_OVERRANGE_FLAG)
    else $error("ones pattern wrong");
  a_checker_toggle: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    live && !I_REG_WR && pattern == fmt_pkg::PAT_CHECKER
    ##1 I_CE && !I_REG_WR && I_SAMPLE_VALID
    |=> {O_OVERRANGE_FLAG, O_SAMPLE_BITS} ==
      ~$past({O_OVERRANGE_FLAG, O_SAMPLE_BITS}) &&
      ({O_OVERRANGE_FLAG, O_SAMPLE_BITS} == 15'h55A5 ||
      {O_OVERRANGE_FLAG, O_SAMPLE_BITS} == 15'h2A5A))
    else $error("checkerboard did not toggle");
  a_all_toggle: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    live && !I_REG_WR && pattern == fmt_pkg::PAT_TOGGLE
    ##1 I_CE && !I_REG_WR && I_SAMPLE_VALID
    |=> {O_OVERRANGE_FLAG, O_SAMPLE_BITS} ==
      ~$past({O_OVERRANGE_FLAG, O_SAMPLE_BITS}) &&
      (O_SAMPLE_BITS == 14'h0000 || O_SAMPLE_BITS == 14'h3FFF))
    else $error("all-bit toggle wrong");
  a_polarity_odd: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    live && state_r.output_data_format == 6'h04
    |=> O_SAMPLE_BITS == ($past(I_SAMPLE_BITS) ^ 14'h2AAA))
    else $error("odd bits not inverted");
  a_scramble_lsb: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    live && state_r.output_data_format == 6'h02
    |=> O_SAMPLE_BITS == ($past(I_SAMPLE_BITS) ^ {{13{$past(I_SAMPLE_BITS[0])}}, 1'b0}))
    else $error("scrambler wrong");
  a_signed_msb: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    live && state_r.output_data_format == 6'h01
    |=> O_SAMPLE_BITS == ($past(I_SAMPLE_BITS) ^ 14'h2000))
    else $error("two's complement wrong");
  a_polarity_forces: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    live && state_r.output_data_format == 6'h05
    |=> O_SAMPLE_BITS == ($past(I_SAMPLE_BITS) ^ 14'h2AAA))
    else $error("signed select not overridden");
  a_soft_reset: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_CE && I_REG_WR && I_REG_ADDR == fmt_pkg::RESET_REG_ADDR &&
    I_REG_WDATA[fmt_pkg::SOFT_RESET_BIT]
    |=> state_r.output_data_format == 6'h00 && !state_r.phase)
    else $error("software reset failed");
  a_spare_bits: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    O_REG_RVALID |-> O_REG_RDATA[7:6] == 2'h0)
    else $error("spare bits read nonzero");
  // Strobe and register path
  a_sample_strobe: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_CE |=> O_SAMPLE_VALID == $past(I_SAMPLE_VALID))
    else $error("sample strobe not one cycle later");
  a_format_write: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_CE && I_REG_WR && I_REG_ADDR == fmt_pkg::FORMAT_REG_ADDR
    |=> state_r.output_data_format == $past(I_REG_WDATA[5:0]))
    else $error("format write not stored");
  a_format_read: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_CE && I_REG_RD && I_REG_ADDR == fmt_pkg::FORMAT_REG_ADDR
    |=> O_REG_RVALID && O_REG_RDATA == {2'h0, $past(state_r.output_data_format)})
    else $error("format read back wrong");
  // A toggle pattern must open on its first word, so the phase rests low
  a_phase_parked: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_CE && !toggling |=> !state_r.phase)
    else $error("pattern phase not parked");
endmodule
`default_nettype wire

//--- tb/word_capture.sv
`default_nettype none
// Capturing logic on the far side: stores every formatted word it sees
module word_capture (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Formatted samples from the block
  input wire logic valid,
  input wire logic [13:0] bits,
  input wire logic flag
);
  timeunit 1ns;
  timeprecision 100ps;
  // Captured words, flag in the top bit, oldest first
  logic [14:0] words[$];
  // Takes a word only on its strobe, the way a real capture register would
  always @(posedge clk)
  begin
    if (rst_n && valid === 1'b1)
    begin
      words.push_back({flag, bits});
    end
  end
endmodule
`default_nettype wire

//--- tb/test_adc_output_data_formatter.sv
`default_nettype none
// Self-checking bench for the output data formatter
module test_adc_output_data_formatter;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0; // 100 MHz clock
  logic rst_n = 1'b0; // Synchronous reset, active low
  logic ce = 1'b1; // Clock enable
  logic wr = 1'b0, rd = 1'b0; // Register strobes
  logic [6:0] addr = 7'h00; // Register address
  logic [7:0] wdata = 8'h00, rdata, d; // Write data, read data, read result
  logic rvalid, ov, of, sv = 1'b0, so = 1'b0; // Strobes and flags
  logic [13:0] ob, sb = 14'h0000; // Sample bits out and in
  logic [14:0] w; // Word taken from the capture model
  int err_total = 0, check_count = 0, cycles = 0;
  always #5 clk = ~clk;
  adc_output_data_formatter i_dut (.I_CLK(clk), .I_RST_N(rst_n), .I_CE(ce),
    .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_ADDR(addr), .I_REG_WDATA(wdata),
    .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid), .I_SAMPLE_VALID(sv),
    .I_SAMPLE_BITS(sb), .I_OVERRANGE_FLAG(so), .O_SAMPLE_VALID(ov),
    .O_SAMPLE_BITS(ob), .O_OVERRANGE_FLAG(of));
  word_capture i_cap (.clk(clk), .rst_n(rst_n), .valid(ov), .bits(ob), .flag(of));
  // Expected word from the format setting; patterns bypass all coding
  function automatic logic [14:0] model(logic [5:0] f, logic [13:0] b, logic o, logic ph);
    logic [13:0] c;
    case (f[5:3])
      3'b001: return 15'h0000;
      3'b011: return 15'h7FFF;
      3'b101: return ph ? 15'h2A5A : 15'h55A5;
      3'b111: return ph ? 15'h7FFF : 15'h0000;
      default: c = b;
    endcase
    // Polarity alternation wins over the signed select
    if (f[2]) c = b ^ 14'h2AAA;
    else if (f[0]) c = b ^ 14'h2000;
    if (f[1]) c[13:1] = c[13:1] ^ {13{c[0]}};
    return {o, c};
  endfunction
  // Inputs always move 1 ns after the edge, never on it
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [14:0] seen, input logic [14:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Idle cycle after each strobe so no strobe is set twice in one step
  task automatic reg_wr(input logic [6:0] a, input logic [7:0] v);
    wr = 1'b1;
    addr = a;
    wdata = v;
    tick;
    wr = 1'b0;
    tick;
  endtask
  // Read data is taken once its valid strobe arrives, one cycle after the read strobe
  task automatic reg_rd(input logic [6:0] a, output logic [7:0] v);
    int n;
    rd = 1'b1;
    addr = a;
    tick;
    rd = 1'b0;
    n = 0;
    while (rvalid !== 1'b1 && n < 4)
    begin
      tick;
      n++;
    end
    v = (rvalid === 1'b1) ? rdata : 8'hXX;
    tick;
  endtask
  // Holds the strobe for n back-to-back samples of one value
  task automatic send(input logic [13:0] b, input logic o, input int n);
    sv = 1'b1;
    sb = b;
    so = o;
    repeat (n) tick;
    sv = 1'b0;
    tick;
  endtask
  // Oldest captured word; unknown if none arrives in time
  task automatic get(output logic [14:0] v);
    int n;
    n = 0;
    while (i_cap.words.size() == 0 && n < 6)
    begin
      tick;
      n++;
    end
    v = (i_cap.words.size() > 0) ? i_cap.words.pop_front() : 15'hXXXX;
  endtask
  task automatic results;
    $display("checks=%0d mismatches=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_total++;
      results;
    end
  end
  initial
  begin
    repeat (10) tick;
    rst_n = 1'b1;
    tick;
    // Register reset value, unmapped read, dropped top bits, soft reset
    reg_rd(7'h04, d);
    check({7'h00, d}, 15'h0000);
    reg_rd(7'h10, d);
    check({7'h00, d}, 15'h0000);
    reg_wr(7'h04, 8'hFF);
    reg_rd(7'h04, d);
    check({7'h00, d}, 15'h003F);
    reg_wr(7'h00, 8'h80);
    reg_rd(7'h04, d);
    check({7'h00, d}, 15'h0000);
    $display("test registers done");
    // Every combination of the three coding bits, flag low and high
    for (int f = 0; f < 8; f++)
    begin
      reg_wr(7'h04, 8'(f));
      for (int j = 0; j < 2; j++)
      begin
        send(j ? 14'h2A5B : 14'h1234, j[0], 1);
        get(w);
        check(w, model(6'(f), j ? 14'h2A5B : 14'h1234, j[0], 1'b0));
      end
    end
    $display("test coding done");
    // Only the defined pattern codes, with every coding bit set beneath
    for (int p = 0; p < 4; p++)
    begin
      // Codes 001, 011, 101, 111 in turn
      reg_wr(7'h04, {2'b00, 3'(2 * p + 1), 3'b111});
      send(14'h1234, 1'b1, 4);
      for (int k = 0; k < 4; k++)
      begin
        get(w);
        check(w, model({3'(2 * p + 1), 3'b111}, 14'h1234, 1'b1, k[0]));
      end
    end
    reg_wr(7'h04, 8'h00);
    $display("test patterns done");
    // Clock enable low: a strobed sample must not come out
    ce = 1'b0;
    send(14'h0ABC, 1'b0, 1);
    tick;
    check(15'(i_cap.words.size()), 15'h0000);
    ce = 1'b1;
    tick;
    $display("test enable done");
    results;
  end
endmodule
`default_nettype wire
